/* File: inc/pmt_pkg.sv */
// package: register map, field positions and bus carriers of the pwm and measure timers
package pmt_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam int PMT_ADDR_W = 8;
  localparam logic [PMT_ADDR_W-1:0] OFF_PWM_MODE = 8'h00;
  localparam logic [PMT_ADDR_W-1:0] OFF_PWM_DATA = 8'h04;
  localparam logic [PMT_ADDR_W-1:0] OFF_MEAS_MODE = 8'h08;
  localparam logic [PMT_ADDR_W-1:0] OFF_MEAS_DATA = 8'h0c;
  localparam logic [PMT_ADDR_W-1:0] OFF_START = 8'h10;
  localparam logic [PMT_ADDR_W-1:0] OFF_IRQ = 8'h14;

  // ****************************************
  // field positions and encodings
  // ****************************************
  localparam int A_BIT_RISE = 3;
  localparam int A_BIT_EXT = 4;
  localparam int A_BIT_8BIT = 5;
  localparam int SRC_LO = 6;
  localparam int SRC_HI = 7;
  localparam logic [2:0] A_MODE_PWM = 3'h7;
  localparam int B_BIT_E2 = 2;
  localparam int B_BIT_E3 = 3;
  localparam int B_BIT_OVF = 5;
  localparam logic [1:0] B_MODE_TIMER = 2'h0;
  localparam logic [1:0] B_MODE_EVENT = 2'h1;
  localparam logic [1:0] B_MODE_MEAS = 2'h2;
  localparam logic [1:0] EV_FALL = 2'h0;
  localparam logic [1:0] EV_RISE = 2'h1;
  localparam logic [1:0] EV_BOTH = 2'h2;
  localparam int START_PWM = 0;
  localparam int START_MEAS = 1;
  localparam int IRQ_PWM = 0;
  localparam int IRQ_MEAS = 1;

  // ****************************************
  // reset values and counting limits
  // ****************************************
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] PWM16_LAST = 16'hfffe;
  localparam logic [7:0] PWM8_LAST = 8'hfe;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam int DIV_W = 9;
  localparam logic [DIV_W-1:0] SRC_MASK0 = 9'h001;
  localparam logic [DIV_W-1:0] SRC_MASK1 = 9'h007;
  localparam logic [DIV_W-1:0] SRC_MASK2 = 9'h01f;
  localparam logic [DIV_W-1:0] SRC_MASK3 = 9'h0ff;

  typedef enum logic {PWM_IDLE, PWM_RUN} pmt_pwm_state_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [PMT_ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pmt_avs_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } pmt_avs_rsp_s;

  // one-cycle count source tick from the shared divider
  function automatic logic src_tick(input logic [DIV_W-1:0] div, input logic [1:0] sel);
    logic [DIV_W-1:0] m;
    m = SRC_MASK0;
    case (sel)
      2'h1: m = SRC_MASK1;
      2'h2: m = SRC_MASK2;
      2'h3: m = SRC_MASK3;
      default: m = SRC_MASK0;
    endcase
    return (div & m) == '0;
  endfunction

endpackage

/* File: design/pmt_timers.sv */
// design: pwm timer and measure timer behind an avalon-mm slave
`timescale 1ns/1ps

// How it works
// - mode bit 5 low picks the 16-bit modulator, high the 8-bit one.
// - with software trigger, modulation starts once the start bit is one.
// - with external trigger, a chosen trigger edge while started begins modulation.
// - halted writes load reload and counter; running ignores further triggers.
// - 16-bit output is high m ticks in a 65535-tick period.
// - every falling edge of the pulse output sets the interrupt request bit.
// - reload copies into the counter just before each rising edge.
// - reading the modulating timer gives no meaningful count.
// - 8-bit mode low byte is a prescaler of period n+1 ticks.
// - 8-bit mode high byte modulates on prescaler pulses, period 255 of them.
// - measure timer mode bits 1:0 choose timer, event or measurement mode.
// - mode bits 7:6 choose the count source; counting follows start bit.
// - counter counts down, at zero sets request, reloads and keeps going.
// - halted writes load both; busy writes load reload only; counter readable.
// - event mode bits 3:2 choose falling, rising or both input edges.
// - measurement bit 3 low gives period, high gives width between edges.
// - a measuring edge copies counter to reload, clears it, then requests.
// - first capture after start set raises no interrupt request.
// - measurement mode reads return the captured reload value.
// - overflow flag sets at zero, clears on mode write, resets to one.
module pmt_timers (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pmt_pkg::pmt_avs_req_s avs_req,
  output pmt_pkg::pmt_avs_rsp_s avs_rsp,
  input wire logic pwm_trigger_input,
  input wire logic measure_event_input,
  output logic pwm_pulse_output,
  output logic pwm_irq_request,
  output logic measure_irq_request
);
  import pmt_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_d_r;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic [DIV_W-1:0] div_r;
  pmt_avs_rsp_s rsp_r;
  logic [31:0] rd_nxt;
  logic wr_en;
  logic wr_pwm_mode;
  logic wr_pwm_data;
  logic wr_meas_mode;
  logic wr_meas_data;
  logic wr_start;
  logic wr_irq;
  logic [7:0] pwm_mode_r;
  logic [7:0] meas_mode_r;
  logic ovf_r;
  logic [1:0] start_r;
  logic pwm_irq_r;
  logic meas_irq_r;
  pmt_pwm_state_e pwm_state_r;
  logic [15:0] pwm_reload_r;
  logic [15:0] pwm_cnt_r;
  logic [15:0] pwm_ph_r;
  logic pwm_out_r;
  logic [15:0] pwm_wdata;
  logic pwm_tick;
  logic pwm_is_mod;
  logic pwm_8;
  logic pwm_go;
  logic pwm_last;
  logic [15:0] pwm_width;
  logic pwm_out_nxt;
  logic pwm_fall;
  logic [15:0] meas_reload_r;
  logic [15:0] meas_cnt_r;
  logic meas_first_r;
  logic [15:0] meas_wdata;
  logic [1:0] bmode;
  logic [1:0] ev_sel;
  logic meas_tick;
  logic b_run;
  logic ev_hit;
  logic meas_edge;
  logic down_step;
  logic down_zero;
  logic cap;
  logic up_step;
  logic up_wrap;

  // merge 16-bit data under the two low byte enables
  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  // two flops per pin, a third flop for edges on the settled value
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_d_r <= 2'h0;
    end else begin
      pin_s1_r <= {measure_event_input, pwm_trigger_input};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end
  assign pin_rise = pin_s2_r & ~pin_d_r;
  assign pin_fall = ~pin_s2_r & pin_d_r;

  // free-running divider feeding both count sources
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // ****************************************
  // avalon-mm slave
  // ****************************************
  // a write lands on the edge where waitrequest is seen low
  assign wr_en = avs_req.write & ~rsp_r.waitrequest;
  assign wr_pwm_mode = wr_en && (avs_req.address == OFF_PWM_MODE);
  assign wr_pwm_data = wr_en && (avs_req.address == OFF_PWM_DATA);
  assign wr_meas_mode = wr_en && (avs_req.address == OFF_MEAS_MODE);
  assign wr_meas_data = wr_en && (avs_req.address == OFF_MEAS_DATA);
  assign wr_start = wr_en && (avs_req.address == OFF_START);
  assign wr_irq = wr_en && (avs_req.address == OFF_IRQ);
  assign pwm_wdata = be_merge(pwm_reload_r, avs_req.writedata, avs_req.byteenable);
  assign meas_wdata = be_merge(meas_reload_r, avs_req.writedata, avs_req.byteenable);

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (avs_req.address)
      OFF_PWM_MODE: rd_nxt = {24'h00_0000, pwm_mode_r};
      OFF_PWM_DATA: rd_nxt = 32'h0000_0000; // modulating count not readable
      OFF_MEAS_MODE: rd_nxt = {24'h00_0000, meas_mode_r[7:6], ovf_r, meas_mode_r[4:0]};
      OFF_MEAS_DATA: begin
        if (bmode == B_MODE_MEAS) begin
          rd_nxt = {16'h0000, meas_reload_r}; // captured value
        end else begin
          rd_nxt = {16'h0000, meas_cnt_r}; // live count
        end
      end
      OFF_START: rd_nxt = {30'h0000_0000, start_r};
      OFF_IRQ: rd_nxt = {30'h0000_0000, meas_irq_r, pwm_irq_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // one wait state, then answer for one cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsp_r <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
    end else if (rsp_r.waitrequest && (avs_req.read || avs_req.write)) begin
      rsp_r.waitrequest <= 1'b0;
      rsp_r.readdata <= rd_nxt;
    end else begin
      rsp_r.waitrequest <= 1'b1;
    end
  end
  assign avs_rsp = rsp_r;

  // ****************************************
  // control registers
  // ****************************************
  // mode and start registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwm_mode_r <= MODE_RST;
      meas_mode_r <= MODE_RST;
      start_r <= 2'h0;
    end else begin
      if (wr_pwm_mode) begin
        pwm_mode_r <= avs_req.writedata[7:0];
      end
      if (wr_meas_mode) begin
        meas_mode_r <= avs_req.writedata[7:0];
      end
      if (wr_start) begin
        start_r <= avs_req.writedata[1:0]; // shared start address
      end
    end
  end

  // overflow flag: set wins over the clearing mode write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ovf_r <= 1'b1;
    end else if (down_zero || up_wrap) begin
      ovf_r <= 1'b1;
    end else if (wr_meas_mode) begin
      ovf_r <= 1'b0;
    end
  end

  // interrupt request bits, write one to clear, set wins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwm_irq_r <= 1'b0;
      meas_irq_r <= 1'b0;
    end else begin
      if (pwm_fall) begin
        pwm_irq_r <= 1'b1;
      end else if (wr_irq && avs_req.writedata[IRQ_PWM]) begin
        pwm_irq_r <= 1'b0;
      end
      if (down_zero || (cap && !meas_first_r)) begin
        meas_irq_r <= 1'b1;
      end else if (wr_irq && avs_req.writedata[IRQ_MEAS]) begin
        meas_irq_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // pwm timer
  // ****************************************
  assign pwm_tick = src_tick(div_r, pwm_mode_r[SRC_HI:SRC_LO]);
  assign pwm_is_mod = pwm_mode_r[2:0] == A_MODE_PWM;
  assign pwm_8 = pwm_mode_r[A_BIT_8BIT];
  // software trigger or selected trigger pin edge, only while started
  assign pwm_go = pwm_is_mod && start_r[START_PWM] &&
                  (!pwm_mode_r[A_BIT_EXT] ||
                   (pwm_mode_r[A_BIT_RISE] ? pin_rise[0] : pin_fall[0]));
  assign pwm_last = pwm_8 ? (pwm_ph_r[7:0] == PWM8_LAST) : (pwm_ph_r == PWM16_LAST);
  assign pwm_width = pwm_8 ? {8'h00, pwm_cnt_r[15:8]} : pwm_cnt_r;
  assign pwm_out_nxt = (pwm_state_r == PWM_RUN) && (pwm_ph_r < pwm_width);
  assign pwm_fall = pwm_out_r && !pwm_out_nxt;

  // run state: once running, triggers are not looked at
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwm_state_r <= PWM_IDLE;
    end else begin
      unique case (pwm_state_r)
        PWM_IDLE: begin
          if (pwm_go) begin
            pwm_state_r <= PWM_RUN;
          end
        end
        PWM_RUN: begin
          if (!start_r[START_PWM] || !pwm_is_mod) begin
            pwm_state_r <= PWM_IDLE;
          end
        end
      endcase
    end
  end

  // reload register: any write lands here
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwm_reload_r <= DATA_RST;
    end else if (wr_pwm_data) begin
      pwm_reload_r <= pwm_wdata;
    end
  end

  // counter and phase of the modulator
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwm_cnt_r <= DATA_RST;
      pwm_ph_r <= 16'h0000;
    end else if (pwm_state_r == PWM_IDLE) begin
      pwm_ph_r <= 16'h0000;
      if (wr_pwm_data) begin
        pwm_cnt_r <= pwm_wdata; // halted write loads the counter too
      end else if (pwm_go) begin
        pwm_cnt_r <= pwm_reload_r;
      end
    end else if (pwm_tick) begin
      if (!pwm_8) begin
        if (pwm_last) begin
          pwm_ph_r <= 16'h0000;
          pwm_cnt_r <= pwm_reload_r; // just before the rise
        end else begin
          pwm_ph_r <= pwm_ph_r + 16'h0001;
        end
      end else if (pwm_cnt_r[7:0] == 8'h00) begin
        pwm_cnt_r[7:0] <= pwm_reload_r[7:0]; // prescaler pulse and reload
        if (pwm_last) begin
          pwm_ph_r <= 16'h0000;
          pwm_cnt_r[15:8] <= pwm_reload_r[15:8];
        end else begin
          pwm_ph_r <= pwm_ph_r + 16'h0001;
        end
      end else begin
        pwm_cnt_r[7:0] <= pwm_cnt_r[7:0] - 8'h01;
      end
    end
  end

  // pulse output
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwm_out_r <= 1'b0;
    end else begin
      pwm_out_r <= pwm_out_nxt;
    end
  end

  // ****************************************
  // measure timer
  // ****************************************
  assign bmode = meas_mode_r[1:0];
  assign ev_sel = {meas_mode_r[B_BIT_E3], meas_mode_r[B_BIT_E2]};
  assign meas_tick = src_tick(div_r, meas_mode_r[SRC_HI:SRC_LO]);
  assign b_run = start_r[START_MEAS];

  // counted edge in event mode
  always_comb begin
    ev_hit = 1'b0;
    case (ev_sel)
      EV_FALL: ev_hit = pin_fall[1];
      EV_RISE: ev_hit = pin_rise[1];
      EV_BOTH: ev_hit = pin_rise[1] | pin_fall[1];
      default: ev_hit = 1'b0;
    endcase
  end

  // measuring edge: period uses one edge kind, width uses both
  assign meas_edge = meas_mode_r[B_BIT_E3] ? (pin_rise[1] | pin_fall[1]) :
                     (meas_mode_r[B_BIT_E2] ? pin_rise[1] : pin_fall[1]);
  assign down_step = b_run && (((bmode == B_MODE_TIMER) && meas_tick) ||
                               ((bmode == B_MODE_EVENT) && ev_hit));
  assign down_zero = down_step && (meas_cnt_r == 16'h0000);
  assign cap = b_run && (bmode == B_MODE_MEAS) && meas_edge;
  assign up_step = b_run && (bmode == B_MODE_MEAS) && meas_tick && !cap;
  assign up_wrap = up_step && (meas_cnt_r == CNT_MAX);

  // reload: capture buffer in measurement mode, else write target
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meas_reload_r <= DATA_RST;
    end else if (cap) begin
      meas_reload_r <= meas_cnt_r;
    end else if (wr_meas_data) begin
      meas_reload_r <= meas_wdata;
    end
  end

  // counter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meas_cnt_r <= DATA_RST;
    end else if (cap) begin
      meas_cnt_r <= 16'h0000; // restart from next tick
    end else if (wr_meas_data && !b_run) begin
      meas_cnt_r <= meas_wdata;
    end else if (down_zero) begin
      meas_cnt_r <= meas_reload_r;
    end else if (down_step) begin
      meas_cnt_r <= meas_cnt_r - 16'h0001;
    end else if (up_step) begin
      meas_cnt_r <= meas_cnt_r + 16'h0001;
    end
  end

  // first capture after starting raises no request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meas_first_r <= 1'b1;
    end else if (!b_run) begin
      meas_first_r <= 1'b1;
    end else if (cap) begin
      meas_first_r <= 1'b0;
    end
  end

  assign pwm_pulse_output = pwm_out_r;
  assign pwm_irq_request = pwm_irq_r;
  assign measure_irq_request = meas_irq_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_capture;
    cap ##0 (meas_cnt_r != CNT_MAX);
  endsequence

  a_pwm_fall_irq: assert property (pwm_out_r && !pwm_out_nxt |=> pwm_irq_r)
    else $error("pwm fall did not set request");
  a_pwm_sw_start: assert property (pwm_state_r == PWM_IDLE && pwm_is_mod && start_r[START_PWM]
    && !pwm_mode_r[A_BIT_EXT] |=> pwm_state_r == PWM_RUN)
    else $error("software trigger did not start");
  a_pwm_ext_wait: assert property (pwm_state_r == PWM_IDLE && pwm_mode_r[A_BIT_EXT]
    && !pin_rise[0] && !pin_fall[0] |=> pwm_state_r == PWM_IDLE)
    else $error("started without trigger edge");
  a_pwm_halt_load: assert property (pwm_state_r == PWM_IDLE && wr_pwm_data
    |=> pwm_cnt_r == pwm_reload_r)
    else $error("halted write missed counter");
  a_pwm_keep_run: assert property (pwm_state_r == PWM_RUN && start_r[START_PWM] && pwm_is_mod
    && !wr_start && !wr_pwm_mode |=> pwm_state_r == PWM_RUN)
    else $error("modulation stopped");
  a_pwm_rise_load: assert property (pwm_state_r == PWM_RUN && !pwm_8 && pwm_tick && pwm_last
    && !wr_pwm_data |=> pwm_cnt_r == $past(pwm_reload_r) && pwm_ph_r == 16'h0000)
    else $error("reload not copied before rise");
  a_pwm_idle_low: assert property (pwm_state_r == PWM_IDLE |=> !pwm_out_r)
    else $error("output high while idle");
  a_meas_zero_reload: assert property (down_zero && !cap
    |=> meas_cnt_r == $past(meas_reload_r) && meas_irq_r && ovf_r)
    else $error("zero did not reload");
  a_meas_busy_write: assert property (wr_meas_data && b_run && !down_step && !up_step && !cap
    |=> meas_cnt_r == $past(meas_cnt_r))
    else $error("busy write touched counter");
  a_meas_capture: assert property (s_capture |=> meas_reload_r == $past(meas_cnt_r)
    && meas_cnt_r == 16'h0000)
    else $error("capture failed");
  a_meas_first_quiet: assert property (cap && meas_first_r && !meas_irq_r && !down_zero
    |=> !meas_irq_r)
    else $error("first capture raised request");
  a_ovf_write_clear: assert property (wr_meas_mode && !down_zero && !up_wrap
    |=> !ovf_r ##1 (ovf_r == $past(down_zero || up_wrap) || ovf_r == 1'b0))
    else $error("overflow not cleared");

endmodule

/* File: tb/pmt_pin_model.sv */
// partner model: pulse sources on the timer input pins
`timescale 1ns/1ps
module pmt_pin_model (
  input wire logic clk_sys,
  output logic pwm_trigger_input,
  output logic measure_event_input
);
  // both pins idle low
  initial begin
    pwm_trigger_input = 1'b0;
    measure_event_input = 1'b0;
  end

  // n pulses of h clocks high and l low; no level shorter than two ticks
  task automatic pulses(input int n, input int h, input int l);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys) measure_event_input <= 1'b1;
      repeat (h) @(posedge clk_sys);
      measure_event_input <= 1'b0;
      repeat (l - 1) @(posedge clk_sys);
    end
  endtask

  // move the trigger pin to a new level, giving one edge
  task automatic trig(input logic lvl);
    @(posedge clk_sys) pwm_trigger_input <= lvl;
  endtask
endmodule

/* File: tb/pmt_timers_tb.sv */
// testbench: register bus, measure timer modes and pwm output timing
`timescale 1ns/1ps
module pmt_timers_tb;
  import pmt_pkg::*;

  typedef struct packed {logic [7:0] a; logic [31:0] e;} pmt_row_s;
  typedef struct packed {logic [1:0] e; logic [31:0] k;} pmt_ev_s;
  typedef struct packed {logic [31:0] m; logic q; logic [31:0] lo; logic [31:0] hi;} pmt_ms_s;

  logic clk_sys;
  logic arst_n;
  pmt_avs_req_s avs_req;
  pmt_avs_rsp_s avs_rsp;
  logic pwm_trigger_input;
  logic measure_event_input;
  logic pwm_pulse_output;
  logic pwm_irq_request;
  logic measure_irq_request;
  logic [31:0] rd_q;
  logic [31:0] v;
  int error_cnt = 0;
  int n_checks = 0;
  int hi;
  int per;

  // register values after reset, unmapped place last
  pmt_row_s rst_rows[6] = '{'{OFF_PWM_MODE, 32'h0}, '{OFF_MEAS_MODE, 32'h20},
    '{OFF_START, 32'h0}, '{OFF_IRQ, 32'h0}, '{OFF_MEAS_DATA, 32'h0}, '{8'h18, 32'h0}};
  // event edge select and edges counted by three pulses
  pmt_ev_s ev_rows[3] = '{'{EV_FALL, 32'd3}, '{EV_RISE, 32'd3}, '{EV_BOTH, 32'd6}};
  // measure mode, request after first pulse, captured tick range
  pmt_ms_s ms_rows[3] = '{'{32'h02, 1'b0, 32'd27, 32'd29},
    '{32'h06, 1'b0, 32'd27, 32'd29}, '{32'h0a, 1'b1, 32'd7, 32'd9}};

  pmt_timers i_dut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .avs_req(avs_req),
    .avs_rsp(avs_rsp),
    .pwm_trigger_input(pwm_trigger_input),
    .measure_event_input(measure_event_input),
    .pwm_pulse_output(pwm_pulse_output),
    .pwm_irq_request(pwm_irq_request),
    .measure_irq_request(measure_irq_request)
  );

  pmt_pin_model i_pin (
    .clk_sys(clk_sys),
    .pwm_trigger_input(pwm_trigger_input),
    .measure_event_input(measure_event_input)
  );

  // ********************
  // clock and shared tasks
  // ********************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] h);
    n_checks++;
    if ((g >= lo && g <= h) !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h..%h", $time, g, lo, h);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  // no local limit: only the watchdog ends a wait for the answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clk_sys);
    end while (avs_rsp.waitrequest !== 1'b0);
    rd_q = avs_rsp.readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] h);
    bus(1'b0, a, 32'h0);
    rng(rd_q, lo, h);
  endtask

  // clocks high, then clocks from rise to next rise
  task automatic pwm_meas(output int h, output int p);
    int n;
    n = 0;
    while (pwm_pulse_output !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    h = 0;
    while (pwm_pulse_output === 1'b1 && h < 4000) begin
      @(posedge clk_sys);
      h++;
    end
    p = h;
    while (pwm_pulse_output !== 1'b1 && p < 4000) begin
      @(posedge clk_sys);
      p++;
    end
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog cuts a hang short
  initial begin
    #(40 * 60000);
    error_cnt++;
    report_and_stop();
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    avs_req = '0;
    arst_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    rng(avs_rsp.waitrequest, 1, 1);
    rng(pwm_pulse_output, 0, 0);
    arst_n <= 1'b1;
    foreach (rst_rows[i]) rdc(rst_rows[i].a, rst_rows[i].e, rst_rows[i].e);
    // timer mode
    wr(OFF_MEAS_DATA, 32'd5);
    rdc(OFF_MEAS_DATA, 5, 5);
    wr(OFF_MEAS_MODE, 32'h0);
    rdc(OFF_MEAS_MODE, 0, 0);
    wr(OFF_START, 32'h2);
    repeat (30) @(posedge clk_sys);
    rng(measure_irq_request, 1, 1);
    rdc(OFF_MEAS_MODE, 32'h20, 32'h20);
    wr(OFF_MEAS_DATA, 32'h1234);
    rdc(OFF_MEAS_DATA, 0, 5);
    wr(OFF_START, 32'h0);
    rdc(OFF_MEAS_DATA, 0, 32'h1234);
    v = rd_q;
    repeat (20) @(posedge clk_sys);
    rdc(OFF_MEAS_DATA, v, v);
    // event counter, each edge select
    foreach (ev_rows[i]) begin
      wr(OFF_START, 32'h0);
      wr(OFF_MEAS_DATA, 32'd100);
      wr(OFF_MEAS_MODE, {28'h0, ev_rows[i].e, B_MODE_EVENT});
      wr(OFF_START, 32'h2);
      i_pin.pulses(3, 4, 4);
      repeat (6) @(posedge clk_sys);
      wr(OFF_START, 32'h0);
      rdc(OFF_MEAS_DATA, 100 - ev_rows[i].k, 100 - ev_rows[i].k);
    end
    // period and width measurement
    foreach (ms_rows[i]) begin
      wr(OFF_START, 32'h0);
      wr(OFF_MEAS_MODE, ms_rows[i].m);
      wr(OFF_IRQ, 32'h2);
      wr(OFF_START, 32'h2);
      i_pin.pulses(1, 16, 40);
      repeat (8) @(posedge clk_sys);
      rng(measure_irq_request, ms_rows[i].q, ms_rows[i].q);
      i_pin.pulses(3, 16, 40);
      repeat (8) @(posedge clk_sys);
      rng(measure_irq_request, 1, 1);
      rdc(OFF_MEAS_DATA, ms_rows[i].lo, ms_rows[i].hi);
    end
    wr(OFF_START, 32'h0);
    // timer mode on the divide-by-8 source: four steps take 25 to 32 clocks
    wr(OFF_MEAS_DATA, 32'd3);
    wr(OFF_MEAS_MODE, 32'h40);
    wr(OFF_IRQ, 32'h2);
    wr(OFF_START, 32'h2);
    repeat (20) @(posedge clk_sys);
    rng(measure_irq_request, 0, 0);
    repeat (20) @(posedge clk_sys);
    rng(measure_irq_request, 1, 1);
    wr(OFF_START, 32'h0);
    // 8-bit pwm, software start, width change while running
    wr(OFF_PWM_DATA, 32'h0304);
    wr(OFF_PWM_MODE, 32'h27);
    wr(OFF_START, 32'h1);
    pwm_meas(hi, per);
    // the first pulse may lose part of a source tick; judge a steady one
    pwm_meas(hi, per);
    rng(hi, 30, 30);
    rng(per, 2550, 2550);
    rng(pwm_irq_request, 1, 1);
    rdc(OFF_PWM_DATA, 0, 0);
    wr(OFF_PWM_DATA, 32'h0604);
    pwm_meas(hi, per);
    pwm_meas(hi, per);
    rng(hi, 60, 60);
    repeat (80) @(posedge clk_sys);
    wr(OFF_START, 32'h0);
    // 16-bit pwm
    wr(OFF_PWM_DATA, 32'd10);
    wr(OFF_PWM_MODE, 32'h07);
    wr(OFF_START, 32'h1);
    pwm_meas(hi, per);
    // first pulse: the first source tick may come one clock after the start
    rng(hi, 19, 20);
    wr(OFF_START, 32'h0);
    // 8-bit pwm on a rising trigger edge
    wr(OFF_PWM_DATA, 32'h0304);
    wr(OFF_PWM_MODE, 32'h3f);
    wr(OFF_START, 32'h1);
    repeat (200) @(posedge clk_sys);
    rng(pwm_pulse_output, 0, 0);
    i_pin.trig(1'b1);
    pwm_meas(hi, per);
    pwm_meas(hi, per);
    rng(hi, 30, 30);
    // 8-bit pwm on a falling trigger edge
    wr(OFF_START, 32'h0);
    wr(OFF_PWM_MODE, 32'h37);
    wr(OFF_START, 32'h1);
    repeat (20) @(posedge clk_sys);
    rng(pwm_pulse_output, 0, 0);
    i_pin.trig(1'b0);
    pwm_meas(hi, per);
    pwm_meas(hi, per);
    rng(hi, 30, 30);
    // reset in mid-run: overflow flag back to one, pwm outputs low
    wr(OFF_MEAS_MODE, 32'h0);
    rdc(OFF_MEAS_MODE, 0, 0);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rng(pwm_pulse_output, 0, 0);
    rng(pwm_irq_request, 0, 0);
    rng(avs_rsp.waitrequest, 1, 1);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    rdc(OFF_MEAS_MODE, 32'h20, 32'h20);
    rdc(OFF_START, 0, 0);
    report_and_stop();
  end
endmodule
